/* dcr_clear_unit.sv */
// Per-channel clear codes and clear state for all sixteen channels
`default_nettype none
module dcr_clear_unit
  import dcr_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  dcr_clr_if.chan   cif
);

  typedef struct packed {
    logic [DCR_NCHAN-1:0][DCR_CODE_W-1:0] code;
    logic [DCR_NCHAN-1:0]                 clr;
  } dcr_unit_st_t;

  dcr_unit_st_t st_r;
  dcr_unit_st_t st_nxt;

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt = st_r;
    for (int n = 0; n < DCR_NCHAN; n++)
    begin
      // Refused channels keep their code untouched
      if (cif.bcast_wr && cif.bcast_accept[n])
      begin
        st_nxt.code[n] = cif.bcast_code;
      end
      // Pin only acts where the mask bit is zero
      st_nxt.clr[n] = cif.soft_force[n] |
                      (cif.pin_clear & ~cif.pin_ignore[n]);
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign cif.clear_state    = st_r.clr;
  assign cif.ch0_clear_code = st_r.code[0];

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  bcast_copy_a: assert property (
    cif.bcast_wr && cif.bcast_accept[0] |=>
      cif.ch0_clear_code == $past(cif.bcast_code))
    else $error("broadcast code not copied");
  bcast_refuse_a: assert property (
    cif.bcast_wr && !cif.bcast_accept[0] |=> $stable(cif.ch0_clear_code))
    else $error("refused channel took broadcast code");
  pin_mask_a: assert property (
    cif.pin_clear && cif.pin_ignore[0] && !cif.soft_force[0] |=>
      !cif.clear_state[0])
    else $error("masked channel entered clear");
endmodule : dcr_clear_unit
`default_nettype wire

/* dcr_clr_if.sv */
// Carrier between the register slice and the channel clear unit
`default_nettype none
interface dcr_clr_if;
  import dcr_pkg::*;
  logic [DCR_NCHAN-1:0]  pin_ignore;
  logic [DCR_NCHAN-1:0]  bcast_accept;
  logic [DCR_NCHAN-1:0]  soft_force;
  logic                  pin_clear;
  logic                  bcast_wr;
  logic [DCR_CODE_W-1:0] bcast_code;
  logic [DCR_NCHAN-1:0]  clear_state;
  logic [DCR_CODE_W-1:0] ch0_clear_code;
  modport ctrl (output pin_ignore, bcast_accept, soft_force, pin_clear,
                bcast_wr, bcast_code, input clear_state, ch0_clear_code);
  modport chan (input pin_ignore, bcast_accept, soft_force, pin_clear,
                bcast_wr, bcast_code, output clear_state, ch0_clear_code);
endinterface : dcr_clr_if
`default_nettype wire

/* dcr_host.sv */
// Host model that reaches the register slice over its strobe port
`default_nettype none
module dcr_host
  import dcr_pkg::*;
(
  input  wire logic                  sys_clk_i,
  output logic                       reg_wr_o,
  output logic                       reg_rd_o,
  output logic      [DCR_ADDR_W-1:0] reg_addr_o,
  output logic      [DCR_REG_W-1:0]  reg_wdata_o,
  input  wire logic [DCR_REG_W-1:0]  reg_rdata_i,
  input  wire logic                  reg_rvalid_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Idle address and data are inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_wr_o    <= 1'b1;
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    @(posedge sys_clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output bit ok);
    ok = 1'b0;
    d  = 16'hXXXX;
    @(posedge sys_clk_i);
    reg_rd_o   <= 1'b1;
    reg_addr_o <= a;
    @(posedge sys_clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge sys_clk_i);
      if (reg_rvalid_i === 1'b1)
      begin
        ok = 1'b1;
        d  = reg_rdata_i;
      end
    end
  endtask
endmodule // dcr_host
`default_nettype wire

/* dcr_pkg.sv */
// Constants shared by the clear and reset-flag register slice
`default_nettype none
package dcr_pkg;
  localparam int          DCR_NCHAN      = 16;
  localparam int          DCR_CODE_W     = 12;
  localparam int          DCR_REG_W      = 16;
  localparam int          DCR_ADDR_W     = 8;
  localparam int          DCR_NFLAGS     = 4;
  // Register offsets
  localparam logic [7:0]  DCR_OFS_PIN_MASK = 8'h0D;
  localparam logic [7:0]  DCR_OFS_BCAST    = 8'h0E;
  localparam logic [7:0]  DCR_OFS_FLAGS    = 8'h0F;
  localparam logic [7:0]  DCR_OFS_CH0      = 8'h10;
  // Field positions
  localparam int          DCR_CODE_LSB   = 4;
  localparam int          DCR_CODE_MSB   = 15;
  localparam int          DCR_FLAG_BASE  = 0;
  localparam int          DCR_FLAG_IO    = 1;
  localparam int          DCR_FLAG_PIN   = 2;
  localparam int          DCR_FLAG_COLL  = 3;
  localparam int          DCR_SYNC_CLR   = 4;
  // Reset values and the unmapped read value
  localparam logic [15:0] DCR_RST_PIN_MASK = 16'h0000;
  localparam logic [15:0] DCR_RST_FLAGS    = 16'h000F;
  localparam logic [11:0] DCR_RST_CODE     = 12'h000;
  localparam logic [15:0] DCR_RD_ZERO      = 16'h0000;
endpackage : dcr_pkg
`default_nettype wire

/* dcr_regs.sv */
// Clear mask, broadcast clear code, reset-cause flags and channel 0 code
`default_nettype none
module dcr_regs
  import dcr_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic [DCR_ADDR_W-1:0] reg_addr_i,
  input  wire logic [DCR_REG_W-1:0]  reg_wdata_i,
  output logic      [DCR_REG_W-1:0]  reg_rdata_o,
  output logic                       reg_rvalid_o,
  input  wire logic                  multi_function_pin_i,
  input  wire logic                  analog_supply_collapse_i,
  input  wire logic                  reset_pin_event_i,
  input  wire logic                  io_supply_drop_i,
  input  wire logic                  base_power_on_i,
  input  wire logic [DCR_NCHAN-1:0]  chan_broadcast_accept_i,
  input  wire logic [DCR_NCHAN-1:0]  chan_soft_clear_force_i,
  output logic      [DCR_NCHAN-1:0]  chan_clear_state_o,
  output logic      [DCR_CODE_W-1:0] chan0_drive_code_o
);

  localparam int NSYNC = DCR_NFLAGS + 1;

  typedef struct packed {
    logic [NSYNC-1:0]      sync1;
    logic [NSYNC-1:0]      sync2;
    logic [NSYNC-1:0]      prev;
    logic [DCR_REG_W-1:0]  pin_mask;
    logic [DCR_CODE_W-1:0] bcast_code;
    logic [DCR_NFLAGS-1:0] flags;
    logic [DCR_CODE_W-1:0] ch0_code;
    logic [DCR_REG_W-1:0]  rdata;
    logic                  rvalid;
    logic [DCR_CODE_W-1:0] drive;
  } dcr_st_t;

  dcr_st_t               st_r;
  dcr_st_t               st_nxt;
  logic [NSYNC-1:0]      async_in;
  logic [DCR_NFLAGS-1:0] ev_rise;
  logic                  wr_mask;
  logic                  wr_bcast;
  logic                  wr_flags;
  logic                  wr_ch0;

  dcr_clr_if cif ();

  //////////////////////////////////////////////////////////////////////////
  // Detector and pin levels arrive unsynchronised
  always_comb
  begin
    async_in                = '0;
    async_in[DCR_FLAG_BASE] = base_power_on_i;
    async_in[DCR_FLAG_IO]   = io_supply_drop_i;
    async_in[DCR_FLAG_PIN]  = reset_pin_event_i;
    async_in[DCR_FLAG_COLL] = analog_supply_collapse_i;
    async_in[DCR_SYNC_CLR]  = multi_function_pin_i;
  end

  // Edge taken between second stage and its delayed copy only
  assign ev_rise = st_r.sync2[DCR_NFLAGS-1:0] & ~st_r.prev[DCR_NFLAGS-1:0];

  always_comb
  begin
    wr_mask  = 1'b0;
    wr_bcast = 1'b0;
    wr_flags = 1'b0;
    wr_ch0   = 1'b0;
    if (reg_wr_i && reg_addr_i == DCR_OFS_PIN_MASK)
    begin
      wr_mask = 1'b1;
    end
    else if (reg_wr_i && reg_addr_i == DCR_OFS_BCAST)
    begin
      wr_bcast = 1'b1;
    end
    else if (reg_wr_i && reg_addr_i == DCR_OFS_FLAGS)
    begin
      wr_flags = 1'b1;
    end
    else if (reg_wr_i && reg_addr_i == DCR_OFS_CH0)
    begin
      wr_ch0 = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.sync1 = async_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev  = st_r.sync2;
    if (wr_mask)
    begin
      st_nxt.pin_mask = reg_wdata_i;
    end
    if (wr_bcast)
    begin
      st_nxt.bcast_code = reg_wdata_i[DCR_CODE_MSB:DCR_CODE_LSB];
    end
    if (wr_ch0)
    begin
      st_nxt.ch0_code = reg_wdata_i[DCR_CODE_MSB:DCR_CODE_LSB];
    end
    // Set wins over a same-cycle write so no event is lost
    if (wr_flags)
    begin
      st_nxt.flags = reg_wdata_i[DCR_NFLAGS-1:0] | ev_rise;
    end
    else
    begin
      st_nxt.flags = st_r.flags | ev_rise;
    end
    // Read answer one cycle after the strobe; unmapped reads return zero
    st_nxt.rvalid = reg_rd_i;
    if (reg_rd_i)
    begin
      if (reg_addr_i == DCR_OFS_PIN_MASK)
      begin
        st_nxt.rdata = st_r.pin_mask;
      end
      else if (reg_addr_i == DCR_OFS_BCAST)
      begin
        st_nxt.rdata = {st_r.bcast_code, 4'h0};
      end
      else if (reg_addr_i == DCR_OFS_FLAGS)
      begin
        st_nxt.rdata = {12'h000, st_r.flags};
      end
      else if (reg_addr_i == DCR_OFS_CH0)
      begin
        st_nxt.rdata = {st_r.ch0_code, 4'h0};
      end
      else
      begin
        st_nxt.rdata = DCR_RD_ZERO;
      end
    end
    // Clear code wins while the channel sits in clear
    st_nxt.drive = cif.clear_state[0] ? cif.ch0_clear_code
                                      : st_r.ch0_code;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_r            <= '0;
      st_r.pin_mask   <= DCR_RST_PIN_MASK;
      st_r.bcast_code <= DCR_RST_CODE;
      st_r.flags      <= DCR_RST_FLAGS[DCR_NFLAGS-1:0];
      st_r.ch0_code   <= DCR_RST_CODE;
      st_r.drive      <= DCR_RST_CODE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign cif.pin_ignore   = st_r.pin_mask;
  assign cif.bcast_accept = chan_broadcast_accept_i;
  assign cif.soft_force   = chan_soft_clear_force_i;
  assign cif.pin_clear    = st_r.sync2[DCR_SYNC_CLR];
  assign cif.bcast_wr     = wr_bcast;
  assign cif.bcast_code   = reg_wdata_i[DCR_CODE_MSB:DCR_CODE_LSB];

  dcr_clear_unit u_clear (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .cif       (cif)
  );

  assign reg_rdata_o        = st_r.rdata;
  assign reg_rvalid_o       = st_r.rvalid;
  assign chan_clear_state_o = cif.clear_state;
  assign chan0_drive_code_o = st_r.drive;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_pin_seen;
    multi_function_pin_i ##1 multi_function_pin_i ##1 multi_function_pin_i;
  endsequence

  sequence s_flag_armed(int k);
    wr_flags && !reg_wdata_i[k] && !ev_rise[k];
  endsequence

  property p_flag_set(int k);
    $rose(st_r.sync2[k]) |=> st_r.flags[k];
  endproperty

  mask_store_a: assert property (
    wr_mask |=> cif.pin_ignore == $past(reg_wdata_i))
    else $error("pin mask not stored");
  pin_clear_a: assert property (
    s_pin_seen ##0 (st_r.pin_mask[0] == 1'b0)[*3] |=> chan_clear_state_o[0])
    else $error("clear pin did not clear channel 0");
  ch0_read_a: assert property (
    wr_ch0 ##1 !wr_ch0 ##1
      (reg_rd_i && reg_addr_i == DCR_OFS_CH0 && !wr_ch0) |=>
      reg_rvalid_o && reg_rdata_o[3:0] == 4'h0 &&
      reg_rdata_o[15:4] == $past(reg_wdata_i[15:4], 3))
    else $error("channel 0 code readback wrong");
  flag_arm_a: assert property (
    s_flag_armed(DCR_FLAG_PIN) |=> !st_r.flags[DCR_FLAG_PIN])
    else $error("flag not armed by zero write");
  flag_hold_a: assert property (
    !st_r.flags[DCR_FLAG_IO] && !wr_flags && !ev_rise[DCR_FLAG_IO] |=>
      !st_r.flags[DCR_FLAG_IO])
    else $error("armed flag changed without event");
  coll_flag_a: assert property (p_flag_set(DCR_FLAG_COLL))
    else $error("collapse flag not set");
  pin_flag_a: assert property (p_flag_set(DCR_FLAG_PIN))
    else $error("reset pin flag not set");
  io_flag_a: assert property (p_flag_set(DCR_FLAG_IO))
    else $error("io supply flag not set");
  base_flag_a: assert property (p_flag_set(DCR_FLAG_BASE))
    else $error("base power-on flag not set");
  flag_reset_a: assert property (disable iff (1'b0)
    $fell(reset_i) |-> st_r.flags == 4'hF && reg_rdata_o == 16'h0000)
    else $error("flags not at reset value");
  clear_drive_a: assert property (
    chan_clear_state_o[0] |=> chan0_drive_code_o == $past(cif.ch0_clear_code))
    else $error("clear code not driven");
  normal_drive_a: assert property (
    !chan_clear_state_o[0] |=> chan0_drive_code_o == $past(st_r.ch0_code))
    else $error("normal code not driven");
  rsvd_zero_a: assert property (
    reg_rd_i && reg_addr_i == DCR_OFS_FLAGS |=> reg_rdata_o[15:4] == 12'h000)
    else $error("reserved flag bits not zero");

  // Write side: mapped writes store their field, flag writes ORed with events; a set collapse flag and the mask hold without a write
  ch0_store_a: assert property (
    wr_ch0 |=>
      st_r.ch0_code == $past(reg_wdata_i[DCR_CODE_MSB:DCR_CODE_LSB]))
    else $error("channel 0 code not stored");
  bcast_store_a: assert property (
    wr_bcast |=>
      st_r.bcast_code == $past(reg_wdata_i[DCR_CODE_MSB:DCR_CODE_LSB]))
    else $error("broadcast code not stored");
  mask_hold_a: assert property (
    !wr_mask |=> $stable(st_r.pin_mask))
    else $error("pin mask changed without a write");
  // A same-cycle event must beat the arming write
  flag_write_a: assert property (
    wr_flags |=> st_r.flags ==
      ($past(reg_wdata_i[DCR_NFLAGS-1:0]) | $past(ev_rise)))
    else $error("flag write or event lost");
  flag_sticky_a: assert property (
    st_r.flags[DCR_FLAG_COLL] && !wr_flags |=> st_r.flags[DCR_FLAG_COLL])
    else $error("set flag dropped without a write");
  io_arm_a: assert property (
    s_flag_armed(DCR_FLAG_IO) |=> !st_r.flags[DCR_FLAG_IO])
    else $error("interface supply flag not armed");

  // Read side: the answer comes one cycle after the strobe and then stands
  rd_answer_a: assert property (
    reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  rvalid_pulse_a: assert property (
    !reg_rd_i |=> !reg_rvalid_o && $stable(reg_rdata_o))
    else $error("read answer without a read");
  bcast_rsvd_a: assert property (
    reg_rd_i && reg_addr_i == DCR_OFS_BCAST |=> reg_rdata_o[3:0] == 4'h0)
    else $error("reserved broadcast bits not zero");
  ch0_rsvd_a: assert property (
    reg_rd_i && reg_addr_i == DCR_OFS_CH0 |=> reg_rdata_o[3:0] == 4'h0)
    else $error("reserved code bits not zero");
  unmapped_rd_a: assert property (
    reg_rd_i && (reg_addr_i < DCR_OFS_PIN_MASK || reg_addr_i > DCR_OFS_CH0)
      |=> reg_rdata_o == DCR_RD_ZERO)
    else $error("unmapped read not zero");

  // Channel 0 clears on a software force and leaves once nothing holds it
  sequence s_ch0_released;
    !chan_soft_clear_force_i[0] && !(cif.pin_clear && !cif.pin_ignore[0]);
  endsequence

  soft_clear_a: assert property (
    chan_soft_clear_force_i[0] |=> chan_clear_state_o[0])
    else $error("software force did not clear channel 0");
  clear_release_a: assert property (
    s_ch0_released |=> !chan_clear_state_o[0])
    else $error("channel 0 stayed in clear after release");
endmodule : dcr_regs
`default_nettype wire

/* tb_dac_clear_and_reset_flag_regs.sv */
// Self-checking bench for the clear and reset-flag register slice
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h want %h", $time, (a), (e)); end end
module tb_dac_clear_and_reset_flag_regs
  import dcr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk_i;
  logic        reset_i;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rvalid;
  logic        pin;
  logic [3:0]  ev;
  logic [15:0] acc;
  logic [15:0] frc;
  logic [15:0] clr_st;
  logic [11:0] code;
  int          n_errors;
  int          n_compared;

  always #5 sys_clk_i = ~sys_clk_i;

  dcr_host host (.sys_clk_i(sys_clk_i), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata),
    .reg_rvalid_i(rvalid));

  dcr_regs uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .multi_function_pin_i(pin), .analog_supply_collapse_i(ev[3]),
    .reset_pin_event_i(ev[2]), .io_supply_drop_i(ev[1]),
    .base_power_on_i(ev[0]), .chan_broadcast_accept_i(acc),
    .chan_soft_clear_force_i(frc), .chan_clear_state_o(clr_st),
    .chan0_drive_code_o(code));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // A read that never answers ends the run at once
  task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    bit          ok;
    host.rd(a, d, ok);
    if (!ok)
    begin
      n_errors++;
      $display("Error at %0t: read timed out", $time);
      finish_test();
    end
    `CHK(d, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk_rd(DCR_OFS_PIN_MASK, 16'h0000);
    chk_rd(DCR_OFS_BCAST, 16'h0000);
    chk_rd(DCR_OFS_FLAGS, 16'h000F);
    chk_rd(DCR_OFS_CH0, 16'h0000);
    host.wr(8'h11, 16'hFFFF);
    chk_rd(8'h11, 16'h0000);
  endtask

  task automatic t_ch0();
    host.wr(DCR_OFS_CH0, 16'hFFFF);
    chk_rd(DCR_OFS_CH0, 16'hFFF0);
    repeat (2) @(posedge sys_clk_i);
    `CHK(code, 12'hFFF);
  endtask

  // Events go in ascending bit order so each read proves one more flag
  task automatic t_flags();
    logic [3:0] exp;
    exp = 4'h0;
    host.wr(DCR_OFS_FLAGS, 16'hFFF0);
    chk_rd(DCR_OFS_FLAGS, 16'h0000);
    for (int i = 0; i < DCR_NFLAGS; i++)
    begin
      ev <= 4'h1 << i;
      repeat (4) @(posedge sys_clk_i);
      ev <= 4'h0;
      exp = exp | (4'h1 << i);
      chk_rd(DCR_OFS_FLAGS, {12'h000, exp});
    end
  endtask

  task automatic t_bcast();
    host.wr(DCR_OFS_BCAST, 16'hABCF);
    chk_rd(DCR_OFS_BCAST, 16'hABC0);
    frc <= 16'h0001;
    repeat (3) @(posedge sys_clk_i);
    `CHK(clr_st, 16'h0001);
    `CHK(code, 12'hABC);
    acc <= 16'hFFFE;
    host.wr(DCR_OFS_BCAST, 16'h1230);
    repeat (3) @(posedge sys_clk_i);
    `CHK(code, 12'hABC);
    frc <= 16'h0000;
    repeat (3) @(posedge sys_clk_i);
    `CHK(clr_st, 16'h0000);
    `CHK(code, 12'hFFF);
  endtask

  task automatic t_pin();
    host.wr(DCR_OFS_PIN_MASK, 16'h00F0);
    chk_rd(DCR_OFS_PIN_MASK, 16'h00F0);
    pin <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    `CHK(clr_st, 16'hFF0F);
    `CHK(code, 12'hABC);
    pin <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    `CHK(clr_st, 16'h0000);
    host.wr(DCR_OFS_PIN_MASK, 16'hFFFF);
    pin <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    `CHK(clr_st, 16'h0000);
    `CHK(code, 12'hFFF);
    pin <= 1'b0;
  endtask

  // A second reset in mid-run must bring every register back to its default
  task automatic t_rst_again();
    host.wr(DCR_OFS_FLAGS, 16'h0000);
    chk_rd(DCR_OFS_FLAGS, 16'h0000);
    reset_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    `CHK(clr_st, 16'h0000);
    `CHK(code, 12'h000);
    chk_rd(DCR_OFS_FLAGS, 16'h000F);
    chk_rd(DCR_OFS_PIN_MASK, 16'h0000);
    chk_rd(DCR_OFS_CH0, 16'h0000);
    chk_rd(DCR_OFS_BCAST, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_errors   = 0;
    n_compared = 0;
    sys_clk_i  = 1'b0;
    reset_i    = 1'b1;
    pin        = 1'b0;
    ev         = 4'h0;
    acc        = 16'hFFFF;
    frc        = 16'h0000;
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_ch0();
    t_flags();
    t_bcast();
    t_pin();
    t_rst_again();
    finish_test();
  end
endmodule // tb_dac_clear_and_reset_flag_regs
`undef CHK
`default_nettype wire
